// *** verilog/cpu8_decoder.sv ***
// instruction fetch, decode and effective-address unit of an 8-bit cpu.
// assumes a byte-wide memory bus that answers with a one-cycle ack; the
// core executes the decoded result and may redirect the pc (vectors,
// returns) with pc_load_i while the unit waits for an opcode.
//
// Operation
// - inherent: one opcode byte, no operand, no memory address
// - immediate: two bytes, second byte is the data, no address
// - direct: address is zero high byte and operand byte low
// - bit-test branches: three bytes, direct address plus relative offset
// - extended: three bytes, high then low address byte
// - indexed no offset: one byte, address is zero and index
// - indexed 8-bit: two bytes, unsigned index plus byte, 9-bit result
// - indexed 16-bit: three bytes, high/low offset plus unsigned index
// - taken branch adds signed offset to next address, else falls through
// - branches alone use relative addressing; bit-test branches report direct mode
// - read-modify-write stores the altered value back to its source
// - test instruction reads and evaluates but never writes back
// - bit number and branch sense come from opcode, offset third byte
// - bit-test branches copy tested bit into carry always
// - bit set and clear use direct addressing in lowest 256 bytes
// - jump and jump-to-subroutine replace pc flow, no register operand
// - register/memory ops pair accumulator or index with memory operand
// - register/memory set: arithmetic, logic, compares, loads, multiply, stores
// - read-modify-write set: shifts, bit ops, clear, complement, inc/dec, test
// - control ops are inherent: flags, nop, stack reset, returns, traps
// - branch conditions: flags, unsigned compares, irq pin, always, never
`timescale 1ns/1ns
`default_nettype none

module cpu8_decoder
  import cpu8_decode_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // memory bus
  output logic bus_req_o,
  output logic [cpu8_decode_pkg::ADDR_W-1:0] bus_addr_o,
  input wire logic [7:0] bus_data_i,
  input wire logic bus_ack_i,
  // cpu state
  input wire logic [7:0] index_i,
  input wire logic carry_i,
  input wire logic zero_i,
  input wire logic neg_i,
  input wire logic half_i,
  input wire logic int_mask_i,
  input wire logic irq_pin_i,
  input wire logic pc_load_i,
  input wire logic [cpu8_decode_pkg::ADDR_W-1:0] pc_load_val_i,
  // decoded instruction
  output logic done_o,
  output logic [7:0] opcode_o,
  output cpu8_decode_pkg::mode_type mode_o,
  output cpu8_decode_pkg::class_type class_o,
  output logic [1:0] length_o,
  output logic addr_valid_o,
  output logic [cpu8_decode_pkg::ADDR_W-1:0] ea_o,
  output logic [7:0] imm_o,
  output logic use_index_o,
  output logic [3:0] op_code_o,
  output logic [1:0] wb_dest_o,
  output logic [2:0] bit_num_o,
  output logic bit_value_o,
  output logic carry_wr_o,
  output logic carry_val_o,
  output logic branch_taken_o,
  output logic [cpu8_decode_pkg::ADDR_W-1:0] next_pc_o
);
  import cpu8_decode_pkg::*;

  typedef enum logic [4:0] {
    ST_OPC = 5'b00001,
    ST_B1 = 5'b00010,
    ST_B2 = 5'b00100,
    ST_BIT = 5'b01000,
    ST_DONE = 5'b10000
  } state_type;

  state_type state;
  state_type next_state;
  logic [ADDR_W-1:0] pc;
  logic [ADDR_W-1:0] fptr;
  logic [7:0] opc;
  logic [7:0] b1;
  logic [7:0] b2;
  logic tested;

  // instruction length from the opcode group
  function automatic logic [1:0] len_of(input logic [7:0] op);
    logic [1:0] l;
    l = LEN_ONE;
    case (op[7:4])
      GRP_BIT_BRANCH, GRP_EXT, GRP_IX2: l = LEN_THREE;
      GRP_RMW_ACC, GRP_RMW_IDX, GRP_CTRL_LO, GRP_CTRL_HI, GRP_RMW_IX, GRP_IX:
        l = LEN_ONE;
      default: l = LEN_TWO;
    endcase
    return l;
  endfunction

  // decode of the captured opcode, grouped as the encoding table lays it out
  wire [3:0] hi = opc[7:4];
  wire [3:0] lo = opc[3:0];
  wire is_bit_br = (hi == GRP_BIT_BRANCH);
  wire is_bit_sc = (hi == GRP_BIT_SETCLR);
  wire is_bsr = (opc == OPC_BSR);
  wire is_rel = (hi == GRP_REL) || is_bsr;
  wire is_rmw = (hi == GRP_RMW_DIR) || (hi == GRP_RMW_ACC) || (hi == GRP_RMW_IDX)
    || (hi == GRP_RMW_IX1) || (hi == GRP_RMW_IX);
  wire is_mul = (opc == OPC_MUL);
  wire is_ctrl = (hi == GRP_CTRL_LO) || (hi == GRP_CTRL_HI);
  wire is_jump = (hi >= GRP_DIR) && (lo == LO_JUMP || lo == LO_JSR);
  wire is_test = is_rmw && (lo == LO_TEST);
  wire [1:0] len = len_of(opc);

  // addressing mode
  mode_type mode;
  always_comb
  begin
    case (hi)
      GRP_BIT_BRANCH, GRP_BIT_SETCLR, GRP_RMW_DIR, GRP_DIR: mode = MODE_DIR;
      GRP_REL: mode = MODE_REL;
      GRP_RMW_ACC, GRP_RMW_IDX, GRP_CTRL_LO, GRP_CTRL_HI: mode = MODE_INH;
      GRP_IMM: mode = is_bsr ? MODE_REL : MODE_IMM;
      GRP_EXT: mode = MODE_EXT;
      GRP_IX2: mode = MODE_IX2;
      GRP_RMW_IX1, GRP_IX1: mode = MODE_IX1;
      GRP_RMW_IX, GRP_IX: mode = MODE_IX;
      default: mode = MODE_INH;
    endcase
  end

  // instruction class
  class_type cls;
  assign cls = is_bit_br || is_bit_sc ? CLASS_BIT
    : is_rel || is_jump ? CLASS_JUMP_BRANCH
    : is_rmw && !is_mul ? CLASS_RMW
    : is_ctrl ? CLASS_CONTROL
    : CLASS_REG_MEM;

  // effective addresses
  wire [ADDR_W-1:0] ea_dir = {PAGE_ZERO, b1};
  wire [ADDR_W-1:0] ea_ext = {b1, b2};
  wire [ADDR_W-1:0] ea_ix = {PAGE_ZERO, index_i};
  wire [8:0] sum_ix1 = {1'b0, index_i} + {1'b0, b1};
  wire [ADDR_W-1:0] ea_ix1 = {7'h00, sum_ix1};
  wire [ADDR_W-1:0] ea_ix2 = ea_ext + {PAGE_ZERO, index_i};
  wire [ADDR_W-1:0] pc_seq = pc + {14'h0000, len};
  wire [7:0] rel_off = is_bit_br ? b2 : b1;
  wire [ADDR_W-1:0] ea_rel = pc_seq + {{8{rel_off[7]}}, rel_off};

  logic [ADDR_W-1:0] ea;
  always_comb
  begin
    case (mode)
      MODE_DIR: ea = ea_dir;
      MODE_EXT: ea = ea_ext;
      MODE_IX: ea = ea_ix;
      MODE_IX1: ea = ea_ix1;
      MODE_IX2: ea = ea_ix2;
      MODE_REL: ea = ea_rel;
      default: ea = PC_RESET;
    endcase
  end
  wire addr_valid = (mode != MODE_INH) && (mode != MODE_IMM) && (mode != MODE_REL);

  // branch conditions: pairs share a base test, opcode bit 0 inverts it
  logic br_base;
  always_comb
  begin
    case (lo[3:1])
      3'h0: br_base = 1'b1;
      3'h1: br_base = !(carry_i || zero_i);
      3'h2: br_base = !carry_i;
      3'h3: br_base = !zero_i;
      3'h4: br_base = !half_i;
      3'h5: br_base = !neg_i;
      3'h6: br_base = !int_mask_i;
      3'h7: br_base = irq_pin_i;
      default: br_base = 1'b0;
    endcase
  end
  wire bit_taken = (tested == !opc[0]);
  wire taken = is_bsr || is_jump || (is_bit_br ? bit_taken
    : (hi == GRP_REL) && (br_base ^ opc[0]));
  wire [ADDR_W-1:0] next_pc = !taken ? pc_seq : is_jump ? ea : ea_rel;

  // write-back target
  wire [1:0] wb_dest = !is_rmw || is_mul || is_test ? (is_bit_sc ? DEST_MEM : DEST_NONE)
    : hi == GRP_RMW_ACC ? DEST_ACC
    : hi == GRP_RMW_IDX ? DEST_IDX
    : DEST_MEM;

  // sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ST_OPC:
        if (bus_ack_i && !pc_load_i)
          next_state = len_of(bus_data_i) == LEN_ONE ? ST_DONE : ST_B1;
      ST_B1:
        if (bus_ack_i)
          next_state = len == LEN_THREE ? ST_B2 : ST_DONE;
      ST_B2:
        if (bus_ack_i)
          next_state = is_bit_br ? ST_BIT : ST_DONE;
      ST_BIT:
        if (bus_ack_i)
          next_state = ST_DONE;
      ST_DONE: next_state = ST_OPC;
      default: next_state = ST_OPC;
    endcase
  end

  assign bus_req_o = (state != ST_DONE) && !(state == ST_OPC && pc_load_i);
  assign bus_addr_o = (state == ST_BIT) ? ea_dir : fptr;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_OPC;
      pc <= PC_RESET;
      fptr <= PC_RESET;
      opc <= BYTE_RESET;
      b1 <= BYTE_RESET;
      b2 <= BYTE_RESET;
      tested <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_OPC && pc_load_i)
      begin
        pc <= pc_load_val_i;
        fptr <= pc_load_val_i;
      end
      else if (state == ST_DONE)
      begin
        pc <= next_pc;
        fptr <= next_pc;
      end
      else if (bus_ack_i && state != ST_BIT)
        fptr <= fptr + 16'h0001;
      if (state == ST_OPC && bus_ack_i)
        opc <= bus_data_i;
      if (state == ST_B1 && bus_ack_i)
        b1 <= bus_data_i;
      if (state == ST_B2 && bus_ack_i)
        b2 <= bus_data_i;
      if (state == ST_BIT && bus_ack_i)
        tested <= bus_data_i[opc[3:1]];
    end
  end

  // decoded results, loaded with the one-cycle done_o pulse and held until the next decode
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      done_o <= 1'b0;
      opcode_o <= BYTE_RESET;
      mode_o <= MODE_INH;
      class_o <= CLASS_CONTROL;
      length_o <= LEN_ONE;
      addr_valid_o <= 1'b0;
      ea_o <= PC_RESET;
      imm_o <= BYTE_RESET;
      use_index_o <= 1'b0;
      op_code_o <= 4'h0;
      wb_dest_o <= DEST_NONE;
      bit_num_o <= 3'h0;
      bit_value_o <= 1'b0;
      carry_wr_o <= 1'b0;
      carry_val_o <= 1'b0;
      branch_taken_o <= 1'b0;
      next_pc_o <= PC_RESET;
    end
    else
    begin
      done_o <= (state == ST_DONE);
      if (state == ST_DONE)
      begin
        opcode_o <= opc;
        mode_o <= mode;
        class_o <= cls;
        length_o <= len;
        addr_valid_o <= addr_valid;
        ea_o <= ea;
        imm_o <= b1;
        use_index_o <= (cls == CLASS_REG_MEM) && (lo == LO_CPX || lo == LO_LDX
          || lo == LO_STX);
        op_code_o <= lo;
        wb_dest_o <= wb_dest;
        bit_num_o <= opc[3:1];
        bit_value_o <= !opc[0];
        carry_wr_o <= is_bit_br;
        carry_val_o <= tested;
        branch_taken_o <= taken;
        next_pc_o <= next_pc;
      end
    end
  end

endmodule

`default_nettype wire

// *** common/cpu8_decode_pkg.sv ***
// constants for the 8-bit cpu instruction decoder: opcode groups,
// addressing modes, instruction classes, lengths and reset values.
// assumes opcode groups follow the supplied instruction encoding table.
package cpu8_decode_pkg;

  localparam int ADDR_W = 16;

  // addressing modes
  typedef enum logic [2:0] {
    MODE_INH = 3'h0,
    MODE_IMM = 3'h1,
    MODE_DIR = 3'h2,
    MODE_EXT = 3'h3,
    MODE_IX = 3'h4,
    MODE_IX1 = 3'h5,
    MODE_IX2 = 3'h6,
    MODE_REL = 3'h7
  } mode_type;

  // instruction classes
  typedef enum logic [2:0] {
    CLASS_REG_MEM = 3'h0,
    CLASS_RMW = 3'h1,
    CLASS_JUMP_BRANCH = 3'h2,
    CLASS_BIT = 3'h3,
    CLASS_CONTROL = 3'h4
  } class_type;

  // opcode high-nibble groups
  localparam logic [3:0] GRP_BIT_BRANCH = 4'h0;
  localparam logic [3:0] GRP_BIT_SETCLR = 4'h1;
  localparam logic [3:0] GRP_REL = 4'h2;
  localparam logic [3:0] GRP_RMW_DIR = 4'h3;
  localparam logic [3:0] GRP_RMW_ACC = 4'h4;
  localparam logic [3:0] GRP_RMW_IDX = 4'h5;
  localparam logic [3:0] GRP_RMW_IX1 = 4'h6;
  localparam logic [3:0] GRP_RMW_IX = 4'h7;
  localparam logic [3:0] GRP_CTRL_LO = 4'h8;
  localparam logic [3:0] GRP_CTRL_HI = 4'h9;
  localparam logic [3:0] GRP_IMM = 4'ha;
  localparam logic [3:0] GRP_DIR = 4'hb;
  localparam logic [3:0] GRP_EXT = 4'hc;
  localparam logic [3:0] GRP_IX2 = 4'hd;
  localparam logic [3:0] GRP_IX1 = 4'he;
  localparam logic [3:0] GRP_IX = 4'hf;

  // low-nibble codes and whole opcodes with special meaning
  localparam logic [3:0] LO_TEST = 4'hd;
  localparam logic [3:0] LO_JUMP = 4'hc;
  localparam logic [3:0] LO_JSR = 4'hd;
  localparam logic [3:0] LO_CPX = 4'h3;
  localparam logic [3:0] LO_LDX = 4'he;
  localparam logic [3:0] LO_STX = 4'hf;
  localparam logic [7:0] OPC_BSR = 8'had;
  localparam logic [7:0] OPC_MUL = 8'h42;

  // write-back destinations
  localparam logic [1:0] DEST_NONE = 2'h0;
  localparam logic [1:0] DEST_MEM = 2'h1;
  localparam logic [1:0] DEST_ACC = 2'h2;
  localparam logic [1:0] DEST_IDX = 2'h3;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

// *** sim/mem_model.sv ***
// byte memory answering the decoder's read requests
// assumes one clock; wait_n_i sets the stall before each ack
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  // bus
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [15:0] addr_i,
  input wire logic [1:0] wait_n_i,
  output logic ack_o,
  output logic [7:0] data_o
);
  logic [7:0] ram [0:65535];
  logic [1:0] cnt = 2'h0;
  logic [7:0] last = 8'h00;
  assign ack_o = req_i && (cnt == wait_n_i);
  // a released bus shows the inverse of the last byte, never a stale copy
  assign data_o = ack_o ? ram[addr_i] : ~last;
  always_ff @(posedge clk_i)
  begin
    // an unknown request before the decoder leaves reset must not stick in the counter
    if (!req_i || ack_o)
      cnt <= 2'h0;
    else
      cnt <= cnt + 2'h1;
    if (ack_o)
      last <= data_o;
  end
endmodule
`default_nettype wire

// *** sim/cpu8_decoder_checker.sv ***
// port assertions for the instruction decoder
// assumes it is bound into every decoder instance
`timescale 1ns/1ns
`default_nettype none
module cpu8_decoder_checker (
  // watched ports
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic bus_req_o,
  input wire logic bus_ack_i,
  input wire logic [7:0] index_i,
  input wire logic done_o,
  input wire logic [7:0] opcode_o,
  input wire cpu8_decode_pkg::mode_type mode_o,
  input wire cpu8_decode_pkg::class_type class_o,
  input wire logic [1:0] length_o,
  input wire logic addr_valid_o,
  input wire logic [cpu8_decode_pkg::ADDR_W-1:0] ea_o,
  input wire logic [3:0] op_code_o,
  input wire logic [1:0] wb_dest_o,
  input wire logic carry_wr_o,
  input wire logic branch_taken_o,
  input wire logic [cpu8_decode_pkg::ADDR_W-1:0] next_pc_o
);
  import cpu8_decode_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_inh_no_addr: assert property (done_o && mode_o == MODE_INH
    |-> !addr_valid_o && length_o == LEN_ONE) else $error("inherent decode wrong");
  a_imm_two: assert property (done_o && mode_o == MODE_IMM
    |-> !addr_valid_o && length_o == LEN_TWO) else $error("immediate decode wrong");
  a_dir_page: assert property (done_o && mode_o == MODE_DIR
    |-> ea_o[15:8] == PAGE_ZERO && addr_valid_o) else $error("direct page wrong");
  a_bit_br_len: assert property (done_o && opcode_o[7:4] == GRP_BIT_BRANCH
    |-> length_o == LEN_THREE && carry_wr_o) else $error("bit branch decode wrong");
  a_ext_three: assert property (done_o && mode_o == MODE_EXT
    |-> length_o == LEN_THREE) else $error("extended length wrong");
  a_ix_index: assert property (done_o && mode_o == MODE_IX
    |-> ea_o == {PAGE_ZERO, $past(index_i)}) else $error("indexed address wrong");
  a_ix1_span: assert property (done_o && mode_o == MODE_IX1
    |-> ea_o <= 16'h01fe && length_o == LEN_TWO) else $error("ix1 span wrong");
  a_rel_branch: assert property (done_o && mode_o == MODE_REL
    |-> class_o == CLASS_JUMP_BRANCH) else $error("relative outside branch");
  a_tst_no_wb: assert property (done_o && class_o == CLASS_RMW && op_code_o == LO_TEST
    |-> wb_dest_o == DEST_NONE) else $error("test writes back");
  a_jump_flow: assert property (done_o && opcode_o[7:4] >= GRP_DIR && op_code_o == LO_JUMP
    |-> branch_taken_o && next_pc_o == ea_o) else $error("jump target wrong");
  c_rel_taken: cover property (done_o && mode_o == MODE_REL && branch_taken_o);
  c_ext_done: cover property (done_o && mode_o == MODE_EXT);
  c_bus_stall: cover property (bus_req_o && !bus_ack_i);
endmodule
bind cpu8_decoder cpu8_decoder_checker chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .bus_req_o(bus_req_o), .bus_ack_i(bus_ack_i), .index_i(index_i), .done_o(done_o),
  .opcode_o(opcode_o), .mode_o(mode_o), .class_o(class_o), .length_o(length_o),
  .addr_valid_o(addr_valid_o), .ea_o(ea_o), .op_code_o(op_code_o), .wb_dest_o(wb_dest_o),
  .carry_wr_o(carry_wr_o), .branch_taken_o(branch_taken_o), .next_pc_o(next_pc_o));
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the decoder with a memory model
// assumes the model's ram is preloaded by hierarchical writes
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cpu8_decode_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req, ack, done, valid, taken, c_wr, c_val;
  logic pc_load = 1'b0;
  logic zero = 1'b0;
  logic carry = 1'b1;
  logic neg = 1'b0;
  logic half = 1'b0;
  logic mask = 1'b0;
  logic irq = 1'b0;
  logic use_idx, bit_val;
  logic [7:0] opcode;
  logic [3:0] op_code;
  class_type cls;
  logic [15:0] addr, ea, next_pc;
  logic [15:0] pc_val = 16'h0000;
  logic [7:0] data, imm;
  logic [7:0] index = 8'h00;
  logic [1:0] wait_n = 2'h0;
  logic [1:0] len, wb;
  logic [2:0] bit_num;
  mode_type mode;
  int n_fail = 0;
  int checks_done = 0;
  initial forever #50 core_clk_i = ~core_clk_i;
  mem_model mem (.clk_i(core_clk_i), .req_i(req), .addr_i(addr), .wait_n_i(wait_n),
    .ack_o(ack), .data_o(data));
  cpu8_decoder dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_req_o(req),
    .bus_addr_o(addr), .bus_data_i(data), .bus_ack_i(ack), .index_i(index),
    .carry_i(carry), .zero_i(zero), .neg_i(neg), .half_i(half), .int_mask_i(mask),
    .irq_pin_i(irq), .pc_load_i(pc_load), .pc_load_val_i(pc_val), .done_o(done),
    .opcode_o(opcode), .mode_o(mode), .class_o(cls), .length_o(len), .addr_valid_o(valid),
    .ea_o(ea), .imm_o(imm), .use_index_o(use_idx), .op_code_o(op_code), .wb_dest_o(wb),
    .bit_num_o(bit_num), .bit_value_o(bit_val), .carry_wr_o(c_wr), .carry_val_o(c_val),
    .branch_taken_o(taken), .next_pc_o(next_pc));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_done;
    int i;
    i = 0;
    while (done !== 1'b1 && i < 50)
    begin
      @(posedge core_clk_i);
      #1 i++;
    end
    if (done !== 1'b1)
      n_fail++;
  endtask
  // called in a done cycle: redirect the fetch and wait for the next decode
  task automatic exec(input logic [15:0] pc, input logic [7:0] b0, b1, b2);
    mem.ram[pc] = b0;
    mem.ram[pc + 16'h1] = b1;
    mem.ram[pc + 16'h2] = b2;
    pc_load = 1'b1;
    pc_val = pc;
    @(posedge core_clk_i);
    #1 pc_load = 1'b0;
    wait_done();
  endtask
  task automatic t_inh_imm;
    exec(16'h0100, 8'h4c, 8'h00, 8'h00);
    cmp(16'(len), 16'h1);
    cmp(16'(valid), 16'h0);
    cmp(16'(cls), 16'(CLASS_RMW));
    cmp(16'(wb), 16'(DEST_ACC));
    exec(16'h0110, 8'ha6, 8'h5a, 8'h00);
    cmp(16'(imm), 16'h005a);
    cmp(16'(len), 16'h2);
    cmp(16'(valid), 16'h0);
  endtask
  task automatic t_dir_ext;
    exec(16'h0120, 8'hb6, 8'h80, 8'h00);
    cmp(ea, 16'h0080);
    cmp(16'(valid), 16'h1);
    cmp(16'(use_idx), 16'h0);
    wait_n = 2'h2;
    exec(16'h0130, 8'hc6, 8'h12, 8'h34);
    wait_n = 2'h0;
    cmp(ea, 16'h1234);
    cmp(next_pc, 16'h0133);
  endtask
  task automatic t_indexed;
    index = 8'hff;
    exec(16'h0140, 8'hf6, 8'h00, 8'h00);
    cmp(ea, 16'h00ff);
    exec(16'h0150, 8'he6, 8'hff, 8'h00);
    cmp(ea, 16'h01fe);
    exec(16'h0160, 8'hd6, 8'h12, 8'h30);
    cmp(ea, 16'h132f);
    cmp(16'(len), 16'h3);
  endtask
  task automatic t_branch;
    zero = 1'b1;
    exec(16'h0200, 8'h27, 8'h80, 8'h00);
    cmp(16'(taken), 16'h1);
    cmp(next_pc, 16'h0182);
    cmp(16'(mode), 16'(MODE_REL));
    zero = 1'b0;
    exec(16'h0210, 8'h27, 8'h80, 8'h00);
    cmp(16'(taken), 16'h0);
    cmp(next_pc, 16'h0212);
  endtask
  task automatic t_bit_ops;
    mem.ram[16'h0040] = 8'hfe;
    exec(16'h0300, 8'h01, 8'h40, 8'h10);
    cmp(next_pc, 16'h0313);
    cmp(16'(c_val), 16'h0);
    cmp(16'(c_wr), 16'h1);
    cmp(16'(bit_num), 16'h0);
    cmp(16'(cls), 16'(CLASS_BIT));
    exec(16'h0310, 8'h0e, 8'h40, 8'h10);
    cmp(16'(bit_num), 16'h7);
    cmp(16'(taken), 16'h1);
    cmp(16'(c_val), 16'h1);
    exec(16'h0320, 8'h15, 8'h40, 8'h00);
    cmp(ea, 16'h0040);
    cmp(16'(wb), 16'(DEST_MEM));
    cmp(16'(bit_val), 16'h0);
    cmp(16'(c_wr), 16'h0);
  endtask
  task automatic t_rmw_jump;
    exec(16'h0400, 8'h3c, 8'h40, 8'h00);
    cmp(16'(wb), 16'(DEST_MEM));
    exec(16'h0410, 8'h3d, 8'h40, 8'h00);
    cmp(16'(wb), 16'(DEST_NONE));
    exec(16'h0420, 8'hcc, 8'h45, 8'h67);
    cmp(next_pc, 16'h4567);
    cmp(16'(taken), 16'h1);
  endtask
  task automatic t_classes;
    exec(16'h0600, 8'hb3, 8'h20, 8'h00);
    cmp(16'(cls), 16'(CLASS_REG_MEM));
    cmp(16'(use_idx), 16'h1);
    cmp(16'(op_code), 16'h0003);
    cmp(16'(opcode), 16'h00b3);
    exec(16'h0610, 8'h42, 8'h00, 8'h00);
    cmp(16'(cls), 16'(CLASS_REG_MEM));
    cmp(16'(len), 16'h1);
    exec(16'h0620, 8'h9d, 8'h00, 8'h00);
    cmp(16'(cls), 16'(CLASS_CONTROL));
    cmp(16'(mode), 16'(MODE_INH));
  endtask
  task automatic t_conditions;
    exec(16'h0700, 8'h24, 8'h10, 8'h00);
    cmp(16'(taken), 16'h0);
    cmp(next_pc, 16'h0702);
    carry = 1'b0;
    exec(16'h0710, 8'h22, 8'h10, 8'h00);
    cmp(next_pc, 16'h0722);
    exec(16'h0720, 8'h21, 8'h10, 8'h00);
    cmp(16'(taken), 16'h0);
    half = 1'b1;
    neg = 1'b1;
    mask = 1'b1;
    irq = 1'b1;
    exec(16'h0730, 8'h29, 8'h10, 8'h00);
    cmp(16'(taken), 16'h1);
    exec(16'h0740, 8'h2b, 8'h10, 8'h00);
    cmp(16'(taken), 16'h1);
    exec(16'h0750, 8'h2d, 8'h10, 8'h00);
    cmp(16'(taken), 16'h1);
    exec(16'h0760, 8'h2e, 8'h10, 8'h00);
    cmp(16'(taken), 16'h1);
    exec(16'h0770, 8'h2f, 8'h10, 8'h00);
    cmp(16'(taken), 16'h0);
  endtask
  // reset in mid-run from a done cycle, then the first decode from address zero
  task automatic t_reset;
    rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    cmp(16'(done), 16'h0);
    cmp(16'(cls), 16'(CLASS_CONTROL));
    cmp(16'(len), 16'(LEN_ONE));
    cmp(next_pc, PC_RESET);
    cmp(16'(req), 16'h1);
    cmp(addr, PC_RESET);
    rst_i = 1'b0;
    wait_done();
    cmp(16'(opcode), 16'h009d);
    cmp(next_pc, 16'h0001);
  endtask
  initial
  begin
    for (int a = 0; a < 65536; a++)
      mem.ram[a] = 8'h9d;
    repeat (10) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    wait_done();
    t_inh_imm();
    t_dir_ext();
    t_indexed();
    t_branch();
    t_bit_ops();
    t_rmw_jump();
    t_classes();
    t_conditions();
    t_reset();
    test_done();
  end
  initial
  begin
    #300000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
